// ---- asr_dev_end.sv ----
// Purpose: converter end of the serial result readout
// Assumes: master drives a gated serial clock
// Notes: conversion modelled by a timer and a sample input
//
// Function
// RQ1 - new bit on falling edge, held
// RQ2 - first zero driven on first rising edge
// RQ3 - master gives sixteen clock pulses
// RQ4 - four zeros then result, msb first
// RQ5 - lsb after fifteenth fall, then float
// RQ6 - master returns clock low after read
// RQ7 - extra pulses restart, line stays driven
// RQ8 - strobe fall clears counter if clock low
// RQ9 - master stops clock before strobe falls
// RQ10 - master holds clock low while busy
// RQ11 - conversion end drops busy, loads result
// RQ12 - clock may pause, position kept
// RQ13 - bit chosen by counting clock edges
// RQ14 - converter is slave, master makes clock
// RQ15 - master gates clock with select
// RQ16 - master watches busy for end
// RQ17 - master assembles msb first
// RQ18 - master uses idle-low clock, phase one
// RQ19 - strobe fall starts conversion, busy high
// RQ20 - read ends 300 ns before strobe
// RQ21 - line floats and counter at start
module asr_dev_end
	import asr_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	asr_link_if.dev link,
	input wire logic [RES_BITS-1:0] sample_value,
	output logic conv_done
);
	localparam int CW = $clog2(CONV_CYCLES + 1);

	typedef struct packed {
		logic [1:0] sclk_sy;
		logic sclk_d;
		logic [1:0] strobe_sy;
		logic strobe_d;
		logic busy;
		logic [CW-1:0] conv_cnt;
		logic [FRAME_BITS-1:0] frame;
		logic [3:0] bit_cnt;
		logic wrapped;
		logic keep_drive;
		logic dout;
		logic oe_n;
		logic done_p;
	} asr_dev_st_t;

	asr_dev_st_t st_ff;
	asr_dev_st_t nxt_st;
	logic sclk_rise;
	logic sclk_fall;
	logic strobe_fall;

	// ---------------------------------------------
	// frame bit select
	// ---------------------------------------------
	// bit position counts from the frame head, msb first
	function automatic logic frame_bit(
		input logic [FRAME_BITS-1:0] f,
		input logic [3:0] idx
	);
		frame_bit = f[4'(FRAME_BITS - 1) - idx];
	endfunction

	// ---------------------------------------------
	// next state
	// ---------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done_p = 1'b0;
		// pins come from the master's domain: two flops first
		nxt_st.sclk_sy = {st_ff.sclk_sy[0], link.sclk};
		nxt_st.sclk_d = st_ff.sclk_sy[1];
		nxt_st.strobe_sy = {st_ff.strobe_sy[0], link.convert_strobe_n};
		nxt_st.strobe_d = st_ff.strobe_sy[1];
		sclk_rise = st_ff.sclk_sy[1] && !st_ff.sclk_d;
		sclk_fall = !st_ff.sclk_sy[1] && st_ff.sclk_d;
		strobe_fall = !st_ff.strobe_sy[1] && st_ff.strobe_d;

		// conversion timer; busy falling and the conv_done pulse mark the end
		if (strobe_fall) begin
			nxt_st.busy = 1'b1; // RQ19
			nxt_st.conv_cnt = CW'(CONV_CYCLES); // RQ19
		end else if (st_ff.busy) begin
			if (st_ff.conv_cnt <= CW'(1)) begin
				nxt_st.busy = 1'b0; // RQ11
				nxt_st.frame = {LEAD_PAT, sample_value}; // RQ4 RQ11
				nxt_st.done_p = 1'b1;
				nxt_st.conv_cnt = '0;
			end else begin
				nxt_st.conv_cnt = st_ff.conv_cnt - 1'b1;
			end
		end

		// shift side: edges of the master clock walk the frame
		if (strobe_fall && !st_ff.sclk_sy[1]) begin
			// a high clock here leaves position as it was
			nxt_st.bit_cnt = '0; // RQ8
			nxt_st.wrapped = 1'b0; // RQ8
			nxt_st.keep_drive = 1'b0; // RQ8
			nxt_st.oe_n = OE_OFF_N; // RQ8
			nxt_st.dout = 1'b0;
		end else if (sclk_rise && st_ff.bit_cnt == '0) begin
			// frame head goes out early so it is good at first fall
			nxt_st.oe_n = 1'b0; // RQ2
			nxt_st.dout = frame_bit(st_ff.frame, '0); // RQ2
			if (st_ff.wrapped) begin
				nxt_st.keep_drive = 1'b1; // RQ7
			end
		end else if (sclk_fall) begin
			nxt_st.bit_cnt = st_ff.bit_cnt + 1'b1; // RQ12 RQ13
			if (st_ff.bit_cnt == 4'(FRAME_BITS - 1)) begin
				// sixteenth fall: counter wraps to the head
				nxt_st.wrapped = 1'b1;
				nxt_st.oe_n = st_ff.keep_drive ? 1'b0 : OE_OFF_N; // RQ5 RQ7
				nxt_st.dout = frame_bit(st_ff.frame, '0); // RQ7
			end else begin
				nxt_st.dout = frame_bit(st_ff.frame, nxt_st.bit_cnt); // RQ1 RQ13 RQ4
			end
		end
	end

	// ---------------------------------------------
	// registers
	// ---------------------------------------------
	// after reset the line floats with the counter at the head
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.oe_n <= OE_OFF_N; // RQ21
			st_ff.strobe_sy <= {2{STROBE_IDLE}};
			st_ff.strobe_d <= STROBE_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	// converter only listens to the clock, never makes it
	assign link.busy = st_ff.busy; // RQ14
	assign link.serial_result_out = st_ff.dout;
	assign link.serial_result_oe_n = st_ff.oe_n;
	assign conv_done = st_ff.done_p;
endmodule

// ---- asr_fifo.sv ----
// Purpose: small shift fifo for received results
// Assumes: push and pop on the same clock
// Notes: head word sits in entry 0 so outputs are flops
module asr_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 4
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [$clog2(DEPTH+1)-1:0] cnt;
		logic vld;
		logic rdy;
	} asr_fifo_st_t;
	asr_fifo_st_t st_ff;
	asr_fifo_st_t nxt_st;
	logic push;
	logic pop;
	logic [$clog2(DEPTH+1)-1:0] keep;

	// --------------------------------
	// next state
	// --------------------------------
	// pop shifts toward entry 0, push lands after the kept words
	always_comb begin
		nxt_st = st_ff;
		push = in_valid && st_ff.rdy;
		pop = st_ff.vld && out_ready;
		keep = pop ? st_ff.cnt - 1'b1 : st_ff.cnt;
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				nxt_st.mem[i] = st_ff.mem[i+1];
			end
		end
		if (push) begin
			nxt_st.mem[keep] = in_data;
		end
		nxt_st.cnt = push ? keep + 1'b1 : keep;
		nxt_st.vld = (nxt_st.cnt != '0);
		nxt_st.rdy = (nxt_st.cnt != DEPTH[$clog2(DEPTH+1)-1:0]);
	end

	// --------------------------------
	// registers
	// --------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.rdy <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign in_ready = st_ff.rdy;
	assign out_valid = st_ff.vld;
	assign out_data = st_ff.mem[0];
endmodule

// ---- asr_host_end.sv ----
// Purpose: master end: strobes, waits busy, reads frame
// Assumes: one converter on this port
// Notes: results queue in a small fifo with back-pressure
module asr_host_end
	import asr_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC,
	parameter int FIFO_DEPTH = 4
) (
	input wire logic core_clk,
	input wire logic rst,
	asr_link_if.host link,
	input wire logic conv_req,
	output logic req_ready,
	output logic result_valid,
	input wire logic result_ready,
	output logic [RES_BITS-1:0] result_data
);
	typedef enum logic [2:0] {
		H_IDLE, H_STROBE, H_BUSY_HI, H_BUSY_LO, H_READ, H_PUSH, H_GUARD
	} asr_hstate_t;

	typedef struct packed {
		asr_hstate_t state;
		logic [7:0] cnt;
		logic [4:0] bits;
		logic [FRAME_BITS-1:0] shreg;
		logic sclk;
		logic strobe_n;
		logic [1:0] busy_sy;
		logic [1:0] sd_sy;
		logic push_v;
		logic rdy;
	} asr_host_st_t;

	asr_host_st_t st_ff;
	asr_host_st_t nxt_st;
	logic fifo_in_ready;

	// ---------------------------------------------
	// next state
	// ---------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.busy_sy = {st_ff.busy_sy[0], link.busy};
		nxt_st.sd_sy = {st_ff.sd_sy[0], link.serial_result_out_level};
		case (st_ff.state)
			H_IDLE: begin
				// clock already low here, so strobe resets position
				if (conv_req && st_ff.rdy) begin
					nxt_st.rdy = 1'b0;
					nxt_st.strobe_n = 1'b0; // RQ9
					nxt_st.cnt = 8'(STROBE_LOW_CYC - 1);
					nxt_st.state = H_STROBE;
				end
			end
			H_STROBE: begin
				// strobe back high before busy ends
				if (st_ff.cnt == '0) begin
					nxt_st.strobe_n = STROBE_IDLE;
					nxt_st.state = H_BUSY_HI;
				end else begin
					nxt_st.cnt = st_ff.cnt - 1'b1;
				end
			end
			H_BUSY_HI: begin
				if (st_ff.busy_sy[1]) begin
					nxt_st.state = H_BUSY_LO; // RQ16
				end
			end
			H_BUSY_LO: begin
				// clock stays low through the whole conversion
				if (!st_ff.busy_sy[1]) begin
					nxt_st.state = H_READ; // RQ10 RQ16
					nxt_st.cnt = '0;
					nxt_st.bits = '0;
				end
			end
			H_READ: begin
				// divider: the clock is gated, runs only here
				if (st_ff.cnt == 8'(HALF_CYC - 1)) begin
					nxt_st.cnt = '0;
					nxt_st.sclk = !st_ff.sclk; // RQ14 RQ15 RQ18
					if (st_ff.sclk) begin
						// sample at falling edge, msb shifts in first
						nxt_st.shreg = {st_ff.shreg[FRAME_BITS-2:0], st_ff.sd_sy[1]}; // RQ17 RQ18
						nxt_st.bits = st_ff.bits + 1'b1;
						if (st_ff.bits == 5'(FRAME_BITS - 1)) begin
							nxt_st.state = H_PUSH; // RQ3 RQ6
							nxt_st.push_v = 1'b1;
						end
					end
				end else begin
					nxt_st.cnt = st_ff.cnt + 1'b1;
				end
			end
			H_PUSH: begin
				// a full fifo stalls the next conversion here
				if (fifo_in_ready) begin
					nxt_st.push_v = 1'b0;
					nxt_st.cnt = 8'(GUARD_CYC - 1);
					nxt_st.state = H_GUARD;
				end
			end
			H_GUARD: begin
				if (st_ff.cnt == '0) begin
					nxt_st.rdy = 1'b1; // RQ20
					nxt_st.state = H_IDLE;
				end else begin
					nxt_st.cnt = st_ff.cnt - 1'b1;
				end
			end
			default: begin
				nxt_st.state = H_IDLE;
			end
		endcase
	end

	// ---------------------------------------------
	// registers
	// ---------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.state <= H_IDLE;
			st_ff.sclk <= SCLK_IDLE;
			st_ff.strobe_n <= STROBE_IDLE;
			st_ff.rdy <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	asr_fifo #(
		.WIDTH(RES_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(st_ff.push_v),
		.in_ready(fifo_in_ready),
		.in_data(st_ff.shreg[RES_BITS-1:0]),
		.out_valid(result_valid),
		.out_ready(result_ready),
		.out_data(result_data)
	);

	assign link.sclk = st_ff.sclk;
	assign link.convert_strobe_n = st_ff.strobe_n;
	assign req_ready = st_ff.rdy;
endmodule

// ---- asr_link_asserts.sv ----
// Purpose: timing checks on the link between both ends
// Assumes: host half period of at least four core cycles
// Notes: sits beside the interface, no bind
module asr_link_asserts (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic convert_strobe_n,
	input wire logic busy,
	input wire logic serial_result_out,
	input wire logic serial_result_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [4:0] fall_cnt_ff;
	// falls since the strobe; strobe low clears it like the bit position
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			fall_cnt_ff <= 5'h00;
		else if (!convert_strobe_n)
			fall_cnt_ff <= 5'h00;
		else if ($fell(sclk))
			fall_cnt_ff <= fall_cnt_ff + 5'h01;
	end
	sequence strobe_fall_s;
		$fell(convert_strobe_n);
	endsequence
	sequence conv_span_s;
		busy [*6] ##[1:4] !busy;
	endsequence
	busy_start_a: assert property (strobe_fall_s |-> ##[1:4] busy)
		else $error("busy did not follow strobe");
	busy_span_a: assert property ($rose(busy) |-> conv_span_s)
		else $error("busy length wrong");
	clock_idle_a: assert property (busy |-> !sclk)
		else $error("clock ran during conversion");
	strobe_clk_low_a: assert property (strobe_fall_s |-> !sclk && !$past(sclk))
		else $error("strobe fell with clock high");
	drive_start_a: assert property ($fell(serial_result_oe_n) |-> $past(sclk, 3) && !$past(sclk, 4))
		else $error("line driven without first rise");
	float_end_a: assert property ($rose(serial_result_oe_n) |-> $past(sclk, 4) && !$past(sclk, 3)
		&& fall_cnt_ff == 5'h10)
		else $error("line released at wrong fall");
	data_hold_a: assert property (sclk && $past(sclk, 3) && !serial_result_oe_n && !$past(serial_result_oe_n)
		|-> $stable(serial_result_out))
		else $error("data moved while clock high");
	lead_zero_a: assert property (!serial_result_oe_n && fall_cnt_ff < 5'h04 |-> !serial_result_out)
		else $error("leading bit not zero");
endmodule

// ---- asr_link_if.sv ----
// Purpose: wires between converter end and master end
// Assumes: data line is tri-state at the converter
// Notes: an undriven data line shows the inverse of serial_result_out
interface asr_link_if;
	logic sclk;
	logic convert_strobe_n;
	logic busy;
	logic serial_result_out;
	logic serial_result_oe_n;
	logic serial_result_out_level;
	// floating line shows the inverse of serial_result_out, so a stale sample shows up
	assign serial_result_out_level = serial_result_oe_n ? ~serial_result_out : serial_result_out;
	modport dev (
		input sclk,
		input convert_strobe_n,
		output busy,
		output serial_result_out,
		output serial_result_oe_n
	);
	modport host (
		output sclk,
		output convert_strobe_n,
		input busy,
		input serial_result_out_level
	);
endinterface

// ---- asr_pkg.sv ----
// Purpose: shared constants of the serial result readout link
// Assumes: one 40 MHz core clock at both ends
// Notes: timing counts derive from printed times
package asr_pkg;
	// ---------------------------------------------
	// frame layout
	// ---------------------------------------------
	localparam int FRAME_BITS = 16;
	localparam int RES_BITS = 12;
	localparam int LEAD_ZEROS = 4;
	localparam logic [LEAD_ZEROS-1:0] LEAD_PAT = 4'h0;
	// ---------------------------------------------
	// timing
	// ---------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int CONV_TIME_NS = 3800;
	// longest time: round down
	localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int GUARD_NS = 300;
	// least time: round up
	localparam int GUARD_CYC = (GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// first bit needs six cycles (device sync, drive, host sync); eight leaves margin
	localparam int SCLK_HALF_CYC = 8;
	localparam int STROBE_LOW_CYC = 4;
	// ---------------------------------------------
	// reset values
	// ---------------------------------------------
	localparam logic SCLK_IDLE = 1'b0;
	localparam logic STROBE_IDLE = 1'b1;
	localparam logic OE_OFF_N = 1'b1;
endpackage

// ---- tb.sv ----
// Purpose: end to end bench of the readout link
// Assumes: short conversion count keeps the run brief
// Notes: second link has the bench acting as master
module tb
	import asr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic conv_req = 1'b0;
	logic result_ready = 1'b0;
	logic [RES_BITS-1:0] sample_value = 12'h000;
	logic [RES_BITS-1:0] sample2 = 12'h000;
	logic [RES_BITS-1:0] result_data;
	logic req_ready;
	logic result_valid;
	logic conv_done;
	logic [15:0] mon_frame;
	logic [15:0] frame2;
	int mon_bits = 0;
	int done_cnt = 0;
	int err_total = 0;
	int checks = 0;
	asr_link_if link ();
	asr_link_if link2 ();
	asr_dev_end #(.CONV_CYCLES(8)) u_asr_dev_end (.core_clk(core_clk), .rst(rst), .link(link.dev),
		.sample_value(sample_value), .conv_done(conv_done));
	asr_dev_end #(.CONV_CYCLES(8)) u_asr_dev_end2 (.core_clk(core_clk), .rst(rst), .link(link2.dev),
		.sample_value(sample2), .conv_done());
	asr_host_end u_asr_host_end (.core_clk(core_clk), .rst(rst), .link(link.host), .conv_req(conv_req),
		.req_ready(req_ready), .result_valid(result_valid), .result_ready(result_ready),
		.result_data(result_data));
	asr_link_asserts u_asr_link_asserts (.core_clk(core_clk), .rst(rst), .sclk(link.sclk),
		.convert_strobe_n(link.convert_strobe_n), .busy(link.busy),
		.serial_result_out(link.serial_result_out), .serial_result_oe_n(link.serial_result_oe_n));
	always #12.5 core_clk = ~core_clk;
	// ----------------------------------------
	// monitors and checks
	// ----------------------------------------
	// bit must already stand when the master's clock falls
	always @(negedge link.sclk) begin
		mon_frame = {mon_frame[14:0], link.serial_result_out_level};
		mon_bits++;
	end
	always @(negedge core_clk) if (conv_done === 1'b1) done_cnt++;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic request(input logic [11:0] v);
		for (int i = 0; i < 4000 && req_ready !== 1'b1; i++) @(negedge core_clk);
		chk({15'h0, req_ready}, 16'h0001);
		sample_value = v;
		mon_bits = 0;
		conv_req = 1'b1;
		@(negedge core_clk);
		conv_req = 1'b0;
		for (int i = 0; i < 4000 && mon_bits < 16; i++) @(negedge core_clk);
		chk(mon_frame, {4'h0, v});
		repeat (4) @(negedge core_clk);
		chk({15'h0, link.serial_result_oe_n}, 16'h0001);
	endtask
	// fifo fills, fifth result stalls the host, then all drain in order
	task automatic fill_drain();
		logic [11:0] vals [5] = '{12'h000, 12'hfff, 12'ha5c, 12'h801, 12'h3c7};
		foreach (vals[i]) request(vals[i]);
		repeat (200) @(negedge core_clk);
		chk({14'h0, req_ready, link.convert_strobe_n}, 16'h0001);
		foreach (vals[i]) begin
			for (int k = 0; k < 400 && result_valid !== 1'b1; k++) @(negedge core_clk);
			chk({15'h0, result_valid}, 16'h0001);
			chk({4'h0, result_data}, {4'h0, vals[i]});
			result_ready = 1'b1;
			@(negedge core_clk);
			result_ready = 1'b0;
			@(negedge core_clk);
		end
		chk({15'h0, result_valid}, 16'h0000);
	endtask
	// bench-made clock, off the core clock's phase
	task automatic pulse2(input int n);
		#7;
		repeat (n) begin
			link2.sclk = 1'b1;
			#100;
			// msb arrives first and shifts in at the bottom
			frame2 = {frame2[14:0], link2.serial_result_out_level};
			link2.sclk = 1'b0;
			#100;
		end
	endtask
	// split below sixteen pauses the clock mid-read
	task automatic start2(input logic [11:0] v, input int split);
		sample2 = v;
		@(negedge core_clk);
		link2.convert_strobe_n = 1'b0;
		repeat (4) @(negedge core_clk);
		link2.convert_strobe_n = 1'b1;
		chk({15'h0, link2.busy}, 16'h0001);
		for (int i = 0; i < 400 && link2.busy !== 1'b0; i++) @(negedge core_clk);
		chk({15'h0, link2.busy}, 16'h0000);
		pulse2(split);
		if (split < 16) begin
			#1000;
			pulse2(16 - split);
		end
		chk(frame2, {4'h0, v});
	endtask
	// extra pulses keep the line driven; a clock-low strobe restarts the frame, read in two bursts
	task automatic extra_pulses();
		start2(12'h5a3, 16);
		#300;
		chk({15'h0, link2.serial_result_oe_n}, 16'h0001);
		pulse2(3);
		#300;
		chk({15'h0, link2.serial_result_oe_n}, 16'h0000);
		start2(12'hc3e, 8);
	endtask
	initial begin
		link2.sclk = 1'b0;
		link2.convert_strobe_n = 1'b1;
		repeat (8) @(negedge core_clk);
		rst = 1'b0;
		chk({9'h0, link.sclk, link.convert_strobe_n, link.busy, link.serial_result_oe_n,
			link2.serial_result_oe_n, req_ready, result_valid}, 16'h002e);
		fill_drain();
		extra_pulses();
		chk(16'(done_cnt), 16'h0005);
		final_report();
	end
	initial begin
		#1000000;
		err_total++;
		final_report();
	end
endmodule
